// [src/adc_irq_pkg.sv]
// Package for the converter interrupt logic: register map, bit positions, vector codes.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package adc_irq_pkg;
  // -----------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------
  localparam logic [3:0]  IRQ_ENABLE_OFFSET = 4'h0;
  localparam logic [3:0]  IRQ_FLAGS_OFFSET  = 4'h4;
  localparam logic [3:0]  IRQ_VECTOR_OFFSET = 4'h8;
  localparam int          SRC_COUNT         = 6;
  localparam logic [5:0]  ENABLE_RESET      = 6'h00;
  localparam logic [5:0]  FLAGS_RESET       = 6'h00;

  // -----------------------------------------------------------------
  // Bit positions
  // -----------------------------------------------------------------
  localparam int CONV_DONE_BIT     = 0;
  localparam int INSIDE_WINDOW_BIT = 1;
  localparam int BELOW_WINDOW_BIT  = 2;
  localparam int ABOVE_WINDOW_BIT  = 3;
  localparam int RESULT_OVF_BIT    = 4;
  localparam int CONV_TIME_OVF_BIT = 5;

  // -----------------------------------------------------------------
  // Vector codes
  // -----------------------------------------------------------------
  localparam logic [15:0] VEC_NONE          = 16'h0000;
  localparam logic [15:0] VEC_RESULT_OVF    = 16'h0002;
  localparam logic [15:0] VEC_CONV_TIME_OVF = 16'h0004;
  localparam logic [15:0] VEC_ABOVE_WINDOW  = 16'h0006;
  localparam logic [15:0] VEC_BELOW_WINDOW  = 16'h0008;
  localparam logic [15:0] VEC_INSIDE_WINDOW = 16'h000A;
  localparam logic [15:0] VEC_CONV_DONE     = 16'h000C;

  typedef struct packed {
    logic conv_time_ovf;
    logic result_ovf;
    logic above_window;
    logic below_window;
    logic inside_window;
    logic conv_done;
  } irq_src_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;
endpackage : adc_irq_pkg

// [src/adc_interrupt_logic.sv]
// Interrupt enable, flag and vector logic of a 10-bit converter.
// Assumes event strobes are one-cycle pulses synchronous to clk_in.
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps

// How it works
// - Enable and flag bits 15..6 ignore writes and read zero
// - Enable register holds six read-write enables, reset zero
// - A flag requests an interrupt only while its enable is set
// - Trigger before conversion completes sets flag bit 5
// - New result written before previous read sets flag bit 4
// - Result strictly above upper threshold sets flag bit 3
// - Result below lower threshold sets flag bit 2
// - Result inside the window sets flag bit 1
// - Each completed conversion sets flag bit 0
// - Result read clears done flag; all flags software writable
// - Vector is read-only and reads zero with nothing enabled pending
// - Highest priorities: 02h result, 04h time, 06h above
// - Then 08h below, 0Ah inside, 0Ch done lowest
// - Any write to the vector clears every flag
// - Vector uses only bits 3..1, others zero
module adc_interrupt_logic (
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  input  wire logic                wb_cyc_in,
  input  wire logic                wb_stb_in,
  input  wire logic                wb_we_in,
  input  wire logic [3:0]          wb_adr_in,
  input  wire logic [3:0]          wb_sel_in,
  input  wire logic [31:0]         wb_dat_in,
  output logic      [31:0]         wb_dat_out,
  output logic                     wb_ack_out,
  input  wire adc_irq_pkg::irq_src_t event_in,
  input  wire logic                result_read_in,
  output logic                     irq_out
);

  // -----------------------------------------------------------------
  // Bus slave
  // -----------------------------------------------------------------
  adc_irq_pkg::bus_state_t state_reg;
  logic                    access;
  logic                    wr_lo;
  logic [5:0]              enable_reg;
  logic [5:0]              flags_reg;
  logic [5:0]              flags_next;
  logic [5:0]              pending;
  logic [15:0]             vector;

  // Ack comes one cycle after the request and drops the cycle after
  assign access = wb_cyc_in && wb_stb_in && (state_reg == adc_irq_pkg::BUS_IDLE);
  assign wr_lo  = access && wb_we_in && wb_sel_in[0];

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= adc_irq_pkg::BUS_IDLE;
    end else begin
      case (state_reg)
        adc_irq_pkg::BUS_IDLE: begin
          if (access) begin
            state_reg <= adc_irq_pkg::BUS_ACK;
          end
        end
        adc_irq_pkg::BUS_ACK: begin
          state_reg <= adc_irq_pkg::BUS_IDLE;
        end
        default: begin
          state_reg <= adc_irq_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_out = (state_reg == adc_irq_pkg::BUS_ACK);

  // Writes and read data are taken at the request edge, so ack carries them
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wb_dat_out <= 32'h00000000;
    end else if (access) begin
      case (wb_adr_in)
        adc_irq_pkg::IRQ_ENABLE_OFFSET: wb_dat_out <= {26'h0000000, enable_reg};
        adc_irq_pkg::IRQ_FLAGS_OFFSET:  wb_dat_out <= {26'h0000000, flags_reg};
        adc_irq_pkg::IRQ_VECTOR_OFFSET: wb_dat_out <= {16'h0000, vector};
        default:                        wb_dat_out <= 32'h00000000;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Enable register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      enable_reg <= adc_irq_pkg::ENABLE_RESET;
    end else if (wr_lo && wb_adr_in == adc_irq_pkg::IRQ_ENABLE_OFFSET) begin
      enable_reg <= wb_dat_in[5:0];
    end
  end

  // -----------------------------------------------------------------
  // Flags
  // -----------------------------------------------------------------
  // Hardware set wins over any clear in the same cycle
  always_comb begin
    flags_next = flags_reg;
    if (wr_lo && wb_adr_in == adc_irq_pkg::IRQ_FLAGS_OFFSET) begin
      flags_next = wb_dat_in[5:0];
    end
    if (access && wb_we_in && wb_adr_in == adc_irq_pkg::IRQ_VECTOR_OFFSET) begin
      flags_next = 6'h00;
    end
    if (result_read_in) begin
      flags_next[adc_irq_pkg::CONV_DONE_BIT] = 1'b0;
    end
    flags_next = flags_next | event_in;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flags_reg <= adc_irq_pkg::FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // -----------------------------------------------------------------
  // Vector and request
  // -----------------------------------------------------------------
  assign pending = flags_reg & enable_reg;

  always_comb begin
    if (pending[adc_irq_pkg::RESULT_OVF_BIT]) begin
      vector = adc_irq_pkg::VEC_RESULT_OVF;
    end else if (pending[adc_irq_pkg::CONV_TIME_OVF_BIT]) begin
      vector = adc_irq_pkg::VEC_CONV_TIME_OVF;
    end else if (pending[adc_irq_pkg::ABOVE_WINDOW_BIT]) begin
      vector = adc_irq_pkg::VEC_ABOVE_WINDOW;
    end else if (pending[adc_irq_pkg::BELOW_WINDOW_BIT]) begin
      vector = adc_irq_pkg::VEC_BELOW_WINDOW;
    end else if (pending[adc_irq_pkg::INSIDE_WINDOW_BIT]) begin
      vector = adc_irq_pkg::VEC_INSIDE_WINDOW;
    end else if (pending[adc_irq_pkg::CONV_DONE_BIT]) begin
      vector = adc_irq_pkg::VEC_CONV_DONE;
    end else begin
      vector = adc_irq_pkg::VEC_NONE;
    end
  end

  assign irq_out = |pending;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  a_irq_gating: assert property (@(posedge clk_in) disable iff (reset_in)
    irq_out == |(flags_reg & enable_reg)) else $error("irq not gated by enables");
  a_flag_set: assert property (@(posedge clk_in) disable iff (reset_in)
    event_in.conv_time_ovf |=> flags_reg[5]) else $error("time overflow flag not set");
  a_res_ovf: assert property (@(posedge clk_in) disable iff (reset_in)
    event_in.result_ovf |=> flags_reg[4]) else $error("result overflow flag not set");
  a_done_set: assert property (@(posedge clk_in) disable iff (reset_in)
    event_in.conv_done |=> flags_reg[0]) else $error("done flag not set");
  a_done_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    (result_read_in && !event_in.conv_done && !wr_flags) |=> !flags_reg[0])
    else $error("done flag not cleared by read");
  a_vec_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    (access && wb_we_in && wb_adr_in == adc_irq_pkg::IRQ_VECTOR_OFFSET && event_in == 6'h00)
    |=> flags_reg == 6'h00) else $error("vector write did not clear flags");
  a_vec_zero: assert property (@(posedge clk_in) disable iff (reset_in)
    !irq_out |-> vector == 16'h0000) else $error("vector nonzero when idle");
  a_vec_bits: assert property (@(posedge clk_in) disable iff (reset_in)
    (vector & 16'hFFF1) == 16'h0000) else $error("vector uses illegal bits");
  a_vec_top: assert property (@(posedge clk_in) disable iff (reset_in)
    pending[4] |-> vector == 16'h0002) else $error("result overflow not highest");
  a_ack_once: assert property (@(posedge clk_in) disable iff (reset_in)
    wb_ack_out |=> !wb_ack_out) else $error("ack held two cycles");

  // -----------------------------------------------------------------
  // Check helpers
  // -----------------------------------------------------------------
  // Decodes repeated here so the checks read plainly; they drive no logic
  logic       wr_enable;
  logic       wr_flags;
  logic       wr_vector;
  logic       unmapped;
  logic [5:0] event_bits;

  assign wr_enable  = wr_lo && (wb_adr_in == adc_irq_pkg::IRQ_ENABLE_OFFSET);
  assign wr_flags   = wr_lo && (wb_adr_in == adc_irq_pkg::IRQ_FLAGS_OFFSET);
  assign wr_vector  = access && wb_we_in && (wb_adr_in == adc_irq_pkg::IRQ_VECTOR_OFFSET);
  assign unmapped   = (wb_adr_in != adc_irq_pkg::IRQ_ENABLE_OFFSET)
                   && (wb_adr_in != adc_irq_pkg::IRQ_FLAGS_OFFSET)
                   && (wb_adr_in != adc_irq_pkg::IRQ_VECTOR_OFFSET);
  assign event_bits = event_in;

  // -----------------------------------------------------------------
  // Enable register checks
  // -----------------------------------------------------------------
  // A qualified write lands whole in the six enable bits
  a_en_write: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_enable
    |=> enable_reg == $past(wb_dat_in[5:0]))
    else $error("enable write did not land");

  // Enables only move on their own write
  a_en_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    !wr_enable
    |=> $stable(enable_reg))
    else $error("enable changed without write");

  // Low byte lane off means the write is dropped
  a_en_sel: assert property (@(posedge clk_in) disable iff (reset_in)
    (access && wb_we_in && !wb_sel_in[0])
    |=> $stable(enable_reg))
    else $error("enable written with lane off");

  // Clearing flags through the vector leaves the enables alone
  a_en_vec: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_vector
    |=> $stable(enable_reg))
    else $error("vector write touched enables");

  // Writes to holes in the map go nowhere
  a_en_unmap: assert property (@(posedge clk_in) disable iff (reset_in)
    (access && wb_we_in && unmapped)
    |=> $stable(enable_reg))
    else $error("unmapped write touched enables");

  // -----------------------------------------------------------------
  // Flag checks
  // -----------------------------------------------------------------
  // Window comparator outcomes each set their own flag
  a_above_set: assert property (@(posedge clk_in) disable iff (reset_in)
    event_in.above_window
    |=> flags_reg[3])
    else $error("above flag not set");

  a_below_set: assert property (@(posedge clk_in) disable iff (reset_in)
    event_in.below_window
    |=> flags_reg[2])
    else $error("below flag not set");

  a_inside_set: assert property (@(posedge clk_in) disable iff (reset_in)
    event_in.inside_window
    |=> flags_reg[1])
    else $error("inside flag not set");

  // A plain flag write with no event lands as written
  a_flag_write: assert property (@(posedge clk_in) disable iff (reset_in)
    (wr_flags && event_bits == 6'h00 && !result_read_in)
    |=> flags_reg == $past(wb_dat_in[5:0]))
    else $error("flag write did not land");

  // Without any cause the flags keep their value
  a_flag_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    (!wr_flags && !wr_vector && !result_read_in && event_bits == 6'h00)
    |=> $stable(flags_reg))
    else $error("flags changed without cause");

  // Set beats the vector clear in the same cycle
  a_set_wins: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_vector
    |=> (flags_reg & $past(event_bits)) == $past(event_bits))
    else $error("event lost to vector clear");

  // Set beats the result read clear as well
  a_done_keep: assert property (@(posedge clk_in) disable iff (reset_in)
    (result_read_in && event_in.conv_done)
    |=> flags_reg[0])
    else $error("done event lost to read");

  // Result read touches only the done flag
  a_read_only_done: assert property (@(posedge clk_in) disable iff (reset_in)
    (result_read_in && event_bits == 6'h00 && !wr_flags && !wr_vector)
    |=> flags_reg[5:1] == $past(flags_reg[5:1]))
    else $error("read cleared other flags");

  // Reading the vector is not a clear
  a_vec_read_keep: assert property (@(posedge clk_in) disable iff (reset_in)
    (access && !wb_we_in && !result_read_in && event_bits == 6'h00)
    |=> $stable(flags_reg))
    else $error("read changed flags");

  // Lane off keeps flags, unless something else acts
  a_flag_sel: assert property (@(posedge clk_in) disable iff (reset_in)
    (access && wb_we_in && !wb_sel_in[0] && !wr_vector && !result_read_in
     && event_bits == 6'h00)
    |=> $stable(flags_reg))
    else $error("flags written with lane off");

  // -----------------------------------------------------------------
  // Vector checks
  // -----------------------------------------------------------------
  a_vec_time: assert property (@(posedge clk_in) disable iff (reset_in)
    (pending[5] && !pending[4])
    |-> vector == adc_irq_pkg::VEC_CONV_TIME_OVF)
    else $error("time overflow vector wrong");

  a_vec_above: assert property (@(posedge clk_in) disable iff (reset_in)
    (pending[3] && !(|pending[5:4]))
    |-> vector == adc_irq_pkg::VEC_ABOVE_WINDOW)
    else $error("above vector wrong");

  a_vec_below: assert property (@(posedge clk_in) disable iff (reset_in)
    (pending[2] && !(|pending[5:3]))
    |-> vector == adc_irq_pkg::VEC_BELOW_WINDOW)
    else $error("below vector wrong");

  a_vec_inside: assert property (@(posedge clk_in) disable iff (reset_in)
    (pending[1] && !(|pending[5:2]))
    |-> vector == adc_irq_pkg::VEC_INSIDE_WINDOW)
    else $error("inside vector wrong");

  // Done has the lowest priority, so it shows only alone
  a_vec_done: assert property (@(posedge clk_in) disable iff (reset_in)
    pending == 6'h01
    |-> vector == adc_irq_pkg::VEC_CONV_DONE)
    else $error("done vector wrong");

  // A request always names a source
  a_vec_named: assert property (@(posedge clk_in) disable iff (reset_in)
    irq_out
    |-> vector != adc_irq_pkg::VEC_NONE)
    else $error("request without vector");

  // All enables off silences the request whatever is flagged
  a_mask_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    enable_reg == 6'h00
    |-> !irq_out)
    else $error("request with enables off");

  // -----------------------------------------------------------------
  // Bus checks
  // -----------------------------------------------------------------
  // One cycle answer, never sooner, never unasked
  a_ack_follows: assert property (@(posedge clk_in) disable iff (reset_in)
    access
    |=> wb_ack_out)
    else $error("ack missing after request");

  a_ack_cause: assert property (@(posedge clk_in) disable iff (reset_in)
    wb_ack_out
    |-> $past(access))
    else $error("ack without request");

  a_ack_needs_req: assert property (@(posedge clk_in) disable iff (reset_in)
    !(wb_cyc_in && wb_stb_in)
    |=> !wb_ack_out)
    else $error("ack with no cycle");

  // Read data is the register as it stood at the taking edge
  a_rd_enable: assert property (@(posedge clk_in) disable iff (reset_in)
    (access && wb_adr_in == adc_irq_pkg::IRQ_ENABLE_OFFSET)
    |=> wb_dat_out == {26'h0000000, $past(enable_reg)})
    else $error("enable read data wrong");

  a_rd_flags: assert property (@(posedge clk_in) disable iff (reset_in)
    (access && wb_adr_in == adc_irq_pkg::IRQ_FLAGS_OFFSET)
    |=> wb_dat_out == {26'h0000000, $past(flags_reg)})
    else $error("flag read data wrong");

  a_rd_vector: assert property (@(posedge clk_in) disable iff (reset_in)
    (access && wb_adr_in == adc_irq_pkg::IRQ_VECTOR_OFFSET)
    |=> wb_dat_out == {16'h0000, $past(vector)})
    else $error("vector read data wrong");

  a_rd_unmap: assert property (@(posedge clk_in) disable iff (reset_in)
    (access && unmapped)
    |=> wb_dat_out == 32'h00000000)
    else $error("unmapped read nonzero");

  // Read data stands until the next access
  a_dat_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    !access
    |=> $stable(wb_dat_out))
    else $error("read data moved");

  // Every bit of the flag word follows its own event
  generate
    for (genvar b = 0; b < adc_irq_pkg::SRC_COUNT; b++) begin : g_bit
      a_bit_set: assert property (@(posedge clk_in) disable iff (reset_in)
        event_bits[b]
        |=> flags_reg[b])
        else $error("event bit did not set its flag");
    end
  endgenerate

endmodule : adc_interrupt_logic

// [tb/testbench.sv]
// Self-checking bench for the converter interrupt logic over classic Wishbone.
// Assumes the design answers each bus cycle with a one-cycle ack and a 4-bit byte address.
`timescale 1ns/1ps
module testbench;
  logic                  clk_in      = 1'b0;
  logic                  reset_in    = 1'b1;
  logic                  cyc         = 1'b0;
  logic                  we          = 1'b0;
  logic [3:0]            adr         = 4'h0;
  logic [3:0]            sel         = 4'hF;
  logic [31:0]           wdat        = 32'h0;
  logic [31:0]           dat_out;
  logic                  ack;
  logic                  irq;
  logic                  result_read = 1'b0;
  adc_irq_pkg::irq_src_t ev          = '0;
  int                    error_cnt   = 0;
  int                    tests_run   = 0;
  int                    cycles      = 0;
  logic [15:0]           vec_tab [6] = '{16'h000C, 16'h000A, 16'h0008,
                                         16'h0006, 16'h0002, 16'h0004};
  int                    prio    [6] = '{4, 5, 3, 2, 1, 0};
  logic [31:0]           mask;

  adc_interrupt_logic adc_interrupt_logic_inst (
    .clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(dat_out), .wb_ack_out(ack), .event_in(ev),
    .result_read_in(result_read), .irq_out(irq));

  // ---------------------------------------------------------------
  // Clock, hang guard
  // ---------------------------------------------------------------
  always #2.5 clk_in = ~clk_in;
  // Whole run is well under a thousand cycles, so five thousand means a hang
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("unexpected at %0t: timeout", $time);
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Ack and data are sampled at the rising edge, and released at that same edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_in);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_in); while (ack !== 1'b1);
    q = dat_out;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd

  task automatic irq_is(input logic exp);
    @(negedge clk_in);
    check({31'h0, irq}, {31'h0, exp});
  endtask : irq_is

  task automatic pulse(input logic [5:0] v, input logic rr);
    @(posedge clk_in);
    ev <= v; result_read <= rr;
    @(posedge clk_in);
    ev <= '0; result_read <= 1'b0;
  endtask : pulse

  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'hC, 32'h0);
    wr(4'h0, 32'hFFFFFFFF);
    rd(4'h0, 32'h3F);
    mask = 32'h0;
    for (int k = 5; k >= 0; k--) begin
      mask |= 32'h1 << prio[k];
      wr(4'h4, mask | 32'hFFC0);
      rd(4'h4, mask);
      rd(4'h8, {16'h0, vec_tab[prio[k]]});
    end
    for (int i = 0; i < 6; i++) begin
      wr(4'h0, 32'h1 << i);
      rd(4'h8, {16'h0, vec_tab[i]});
      irq_is(1'b1);
    end
    wr(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    irq_is(1'b0);
    wr(4'h8, 32'h0);
    rd(4'h4, 32'h0);
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i, 1'b0);
      rd(4'h4, 32'h1 << i);
      wr(4'h8, 32'h0000FFFF);
    end
    rd(4'h8, 32'h0);
    wr(4'h0, 32'h1);
    pulse(6'h01, 1'b0);
    irq_is(1'b1);
    pulse(6'h00, 1'b1);
    rd(4'h4, 32'h0);
    irq_is(1'b0);
    sel <= 4'hE;
    wr(4'h0, 32'h3F);
    sel <= 4'hF;
    rd(4'h0, 32'h1);
    wr(4'h4, 32'h21);
    rd(4'h4, 32'h21);
    wr(4'h4, 32'h0);
    rd(4'h4, 32'h0);
    final_report();
  end
endmodule : testbench
